// ===== include/sse_pkg.sv
/*
  Shared constants and types of the state transition engine: table sizes,
  timer units, prescaler counts and the scan sequencer states.
  Assumes a single 250 MHz clock and no software-visible registers.
*/
package sse_pkg;

  // ----------------------------------------------------------------------
  // Table sizes
  // ----------------------------------------------------------------------
  localparam int NUM_STATES = 16;
  localparam int NUM_TRANS  = 16;
  localparam int NUM_LEVELS = 4;
  localparam int NUM_INPUTS = 32;
  localparam int NUM_TIMERS = 6;
  localparam int TVAL_W     = 12;
  localparam int TCNT_W     = 13;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int US_PS         = 1000000;
  localparam int US_CYC        = (US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int US_PER_MS     = 1000;
  localparam int MS_PER_S      = 1000;
  localparam int S_PER_HR      = 3600;
  localparam int MAX_LOOP_US   = 60;
  localparam int EARLY_US      = 30;
  // Thirty microseconds plus one extra for the partial first tick after a restart.
  localparam logic [TCNT_W-1:0] US_MARGIN = 13'h001f;
  localparam logic [TCNT_W-1:0] COARSE_MARGIN = 13'h0001;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    UNIT_US  = 2'h0,
    UNIT_MS  = 2'h1,
    UNIT_SEC = 2'h2,
    UNIT_HR  = 2'h3
  } sse_unit_t;

  typedef enum logic {
    SC_IDLE = 1'b0,
    SC_SCAN = 1'b1
  } sse_scan_t;

endpackage : sse_pkg

// ===== include/sse_tmr_if.sv
/*
  Carrier between the engine and one elapsed-time timer.
  Assumes the engine drives ticks, restart and program; the timer answers.
*/
`timescale 1ns/100ps
interface sse_tmr_if;
  logic [3:0]                   tick;
  logic                         restart;
  logic [sse_pkg::TVAL_W-1:0]   value;
  sse_pkg::sse_unit_t           unit;
  logic                         done;

  modport eng (output tick, output restart, output value, output unit,
               input done);
  modport tmr (input tick, input restart, input value, input unit,
               output done);
endinterface : sse_tmr_if

// ===== rtl/sse_timer.sv
/*
  One elapsed-time timer counting in a selectable unit.
  Assumes one-cycle tick enables per unit from the engine's prescaler.
*/
`timescale 1ns/100ps
module sse_timer (
  input  wire logic   clock,
  input  wire logic   rst_b,
  sse_tmr_if.tmr      t
);

  logic [sse_pkg::TCNT_W-1:0] cnt_q;
  logic [sse_pkg::TCNT_W-1:0] target;
  logic                       unit_tick;
  logic                       is_us;

  assign is_us     = (t.unit == sse_pkg::UNIT_US);
  assign unit_tick = t.tick[t.unit];
  // Fine range carries a fixed margin so it never fires early.
  assign target    = {1'b0, t.value}
                   + (is_us ? sse_pkg::US_MARGIN
                            : sse_pkg::COARSE_MARGIN);
  assign t.done    = (cnt_q >= target);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= '0;
    else if (t.restart)
      cnt_q <= '0;
    else if (unit_tick && !t.done)
      cnt_q <= cnt_q + 13'h0001;
  end

endmodule : sse_timer

// ===== rtl/sse_engine.sv
/*
  Transition evaluation engine of a state machine logic solver.
  Assumes a host loop tick no more often than one scan, static program
  tables on plain ports, and inputs synchronous to the clock.
*/
// What this block does
// - Six independent elapsed-time timers per machine.
// - Timing condition false until duration elapsed.
// - Durations up to 4095 hours accepted.
// - Shortest duration bounded by 60 us loop.
// - Microsecond range fires 30 to 60 us late.
// - Coarser ranges late by one unit at most.
// - All inputs captured together before evaluation.
// - Test transitions by priority, first true wins.
// - No true transition holds present state.
// - True transition moves to its destination.
// - Outer compound states first, simple state last.
`timescale 1ns/100ps
module sse_engine #(
  parameter int NS  = sse_pkg::NUM_STATES,
  parameter int NT  = sse_pkg::NUM_TRANS,
  parameter int NL  = sse_pkg::NUM_LEVELS,
  parameter int NI  = sse_pkg::NUM_INPUTS,
  parameter int NTM = sse_pkg::NUM_TIMERS,
  parameter int SW  = $clog2(NS),
  parameter int TW  = $clog2(NT),
  parameter int LW  = $clog2(NL),
  parameter int IW  = $clog2(NI)
) (
  input  wire logic                                clock,
  input  wire logic                                rst_b,
  input  wire logic                                loop_tick,
  input  wire logic [NI-1:0]                       in_raw,
  input  wire logic [SW-1:0]                       init_state,
  input  wire logic [NT-1:0]                       tr_valid,
  input  wire logic [NT-1:0][SW-1:0]               tr_src,
  input  wire logic [NT-1:0][SW-1:0]               tr_dst,
  input  wire logic [NT-1:0]                       tr_is_timer,
  input  wire logic [NT-1:0][IW-1:0]               tr_sel,
  input  wire logic [NT-1:0]                       tr_inv,
  input  wire logic [NS-1:0][NL-1:0][SW-1:0]       anc_id,
  input  wire logic [NS-1:0][NL-1:0]               anc_ok,
  input  wire logic [NTM-1:0][SW-1:0]              tmr_owner,
  input  wire logic [NTM-1:0][sse_pkg::TVAL_W-1:0] tmr_value,
  input  wire sse_pkg::sse_unit_t [NTM-1:0]        tmr_unit,
  output logic      [SW-1:0]                       cur_state_q,
  output logic                                     step_done_q,
  output logic                                     moved_q,
  output logic      [TW-1:0]                       fired_q,
  output logic                                     busy_q
);

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  logic [7:0]  us_cnt_q;
  logic [9:0]  ms_cnt_q;
  logic [9:0]  s_cnt_q;
  logic [11:0] hr_cnt_q;
  logic [3:0]  tick_q;
  logic        us_wrap;
  logic        ms_wrap;
  logic        s_wrap;
  logic        hr_wrap;

  assign us_wrap = (us_cnt_q == 8'(sse_pkg::US_CYC - 1));
  assign ms_wrap = us_wrap && (ms_cnt_q == 10'(sse_pkg::US_PER_MS - 1));
  assign s_wrap  = ms_wrap && (s_cnt_q == 10'(sse_pkg::MS_PER_S - 1));
  assign hr_wrap = s_wrap && (hr_cnt_q == 12'(sse_pkg::S_PER_HR - 1));

  // Cascaded dividers keep every counter at 12 bits or less while the
  // hour range still reaches 4096 hours.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      us_cnt_q <= '0;
      ms_cnt_q <= '0;
      s_cnt_q  <= '0;
      hr_cnt_q <= '0;
      tick_q   <= '0;
    end
    else
    begin
      us_cnt_q <= us_wrap ? 8'h00 : us_cnt_q + 8'h01;
      if (us_wrap)
        ms_cnt_q <= ms_wrap ? 10'h000 : ms_cnt_q + 10'h001;
      if (ms_wrap)
        s_cnt_q  <= s_wrap ? 10'h000 : s_cnt_q + 10'h001;
      if (s_wrap)
        hr_cnt_q <= hr_wrap ? 12'h000 : hr_cnt_q + 12'h001;
      tick_q   <= {hr_wrap, s_wrap, ms_wrap, us_wrap};
    end
  end

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  logic [NTM-1:0] restart_q;
  logic [NTM-1:0] tdone;
  logic [NTM-1:0] tdone_q;
  logic [NI-1:0]  in_q;

  sse_tmr_if tif [NTM] ();

  generate
    for (genvar g = 0; g < NTM; g++)
    begin : g_tmr
      assign tif[g].tick    = tick_q;
      assign tif[g].restart = restart_q[g];
      assign tif[g].value   = tmr_value[g];
      assign tif[g].unit    = tmr_unit[g];
      assign tdone[g]       = tif[g].done;
      sse_timer u_tmr (
        .clock (clock),
        .rst_b (rst_b),
        .t     (tif[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------------
  sse_pkg::sse_scan_t st_q;
  logic [LW-1:0]    lv_q;
  logic [TW-1:0]    ti_q;
  logic [SW-1:0]    scope;
  logic             scope_ok;
  logic             cand;
  logic             tsel_ok;
  logic             cond;
  logic             hit;
  logic             last_ti;
  logic             last_lv;

  assign scope    = anc_id[cur_state_q][lv_q];
  assign scope_ok = anc_ok[cur_state_q][lv_q];
  assign cand     = tr_valid[ti_q] && scope_ok
                 && (tr_src[ti_q] == scope);
  assign tsel_ok  = (tr_sel[ti_q] < IW'(NTM));
  assign cond     = tr_is_timer[ti_q]
                  ? (tsel_ok && tdone_q[tr_sel[ti_q][2:0]])
                  : (in_q[tr_sel[ti_q]] ^ tr_inv[ti_q]);
  assign hit      = (st_q == sse_pkg::SC_SCAN) && cand && cond;
  assign last_ti  = (ti_q == TW'(NT - 1));
  assign last_lv  = (lv_q == LW'(NL - 1));

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_q    <= '0;
      tdone_q <= '0;
    end
    else if (loop_tick && st_q == sse_pkg::SC_IDLE)
    begin
      in_q    <= in_raw;
      // A timer restarted by the move just made still shows its old done
      // flag for one cycle, so a back-to-back tick must not capture it.
      tdone_q <= tdone & ~restart_q;
    end
  end

  // A one-cycle evaluation per table entry keeps a scan well inside the
  // shortest loop; the loop tick is ignored while a scan is running.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q        <= sse_pkg::SC_IDLE;
      lv_q        <= '0;
      ti_q        <= '0;
      step_done_q <= 1'b0;
      moved_q     <= 1'b0;
      fired_q     <= '0;
      busy_q      <= 1'b0;
    end
    else
    begin
      step_done_q <= 1'b0;
      moved_q     <= 1'b0;
      case (st_q)
        sse_pkg::SC_IDLE:
        begin
          if (loop_tick)
          begin
            st_q   <= sse_pkg::SC_SCAN;
            lv_q   <= '0;
            ti_q   <= '0;
            busy_q <= 1'b1;
          end
        end
        sse_pkg::SC_SCAN:
        begin
          if (hit || (last_ti && last_lv))
          begin
            st_q        <= sse_pkg::SC_IDLE;
            step_done_q <= 1'b1;
            moved_q     <= hit;
            busy_q      <= 1'b0;
            if (hit)
              fired_q <= ti_q;
          end
          else if (last_ti)
          begin
            lv_q <= lv_q + LW'(1);
            ti_q <= '0;
          end
          else
            ti_q <= ti_q + TW'(1);
        end
        default:
          st_q <= sse_pkg::SC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Present state and timer restart
  // ----------------------------------------------------------------------
  logic             init_pend_q;
  logic [NTM-1:0]   enter_own;

  generate
    for (genvar g = 0; g < NTM; g++)
    begin : g_rst
      assign enter_own[g] = hit && (tr_dst[ti_q] == tmr_owner[g]);
    end
  endgenerate

  // The initial state is taken from its port after reset release, never
  // as an asynchronous reset value.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur_state_q <= '0;
      init_pend_q <= 1'b1;
      restart_q   <= '0;
    end
    else
    begin
      init_pend_q <= 1'b0;
      restart_q   <= enter_own;
      if (init_pend_q)
        cur_state_q <= init_state;
      else if (hit)
        cur_state_q <= tr_dst[ti_q];
    end
  end

endmodule : sse_engine

// ===== sim/sse_engine_checker.sv
/*
  Checker of the scan handshake and state update of the engine.
  Assumes it is bound to sse_engine and sees only its top ports.
*/
`timescale 1ns/100ps
module sse_engine_checker #(
  parameter int SW = 4
) (
  input wire logic          clock,
  input wire logic          rst_b,
  input wire logic          loop_tick,
  input wire logic [SW-1:0] cur_state_q,
  input wire logic          step_done_q,
  input wire logic          moved_q,
  input wire logic          busy_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------------
  // Scan properties
  // ----------------------------------------------------------------------
  sequence s_take;
    loop_tick && !busy_q;
  endsequence

  a_take_busy: assert property (s_take |=> busy_q)
    else $error("Tick taken while idle did not start a scan.");
  a_idle_stays: assert property (!busy_q && !loop_tick |=> !busy_q)
    else $error("Scan started without a tick.");
  a_scan_bound: assert property (
    $rose(busy_q) |-> ##[1:65] step_done_q)
    else $error("Scan did not finish in time.");
  a_done_idle: assert property (step_done_q |-> !busy_q)
    else $error("Busy still high at scan end.");
  a_done_pulse: assert property (step_done_q |=> !step_done_q)
    else $error("Scan end held longer than one cycle.");
  a_moved_done: assert property (moved_q |-> step_done_q)
    else $error("Move flagged outside a scan end.");
  a_hold_state: assert property (
    step_done_q && !moved_q |-> $stable(cur_state_q))
    else $error("State changed although nothing fired.");
  // The load of the start state after reset is the only other cause.
  a_change_cause: assert property (
    $changed(cur_state_q) |-> moved_q || !$past(rst_b, 2))
    else $error("State changed without a move.");
endmodule : sse_engine_checker

bind sse_engine sse_engine_checker #(.SW(SW)) chk_u (
  .clock(clock), .rst_b(rst_b), .loop_tick(loop_tick),
  .cur_state_q(cur_state_q), .step_done_q(step_done_q),
  .moved_q(moved_q), .busy_q(busy_q));

// ===== sim/sse_engine_bench.sv
/*
  Self-checking bench of the engine: table of scan cases, timer timing,
  timer restart on re-entry and a reset in mid-run.
  Assumes default table sizes and the checker bound to the engine.
*/
`timescale 1ns/100ps
module sse_engine_bench;
  typedef struct {
    logic [31:0] v;
    logic [31:0] late;
    logic [3:0]  st;
    logic        mv;
    logic [3:0]  fi;
  } sse_row_t;

  logic                  clock, rst_b, loop_tick;
  logic [31:0]           in_raw;
  logic [3:0]            init_state, cur_state_q, fired_q;
  logic [15:0]           tr_valid, tr_is_timer, tr_inv;
  logic [15:0][3:0]      tr_src, tr_dst;
  logic [15:0][4:0]      tr_sel;
  logic [15:0][3:0][3:0] anc_id;
  logic [15:0][3:0]      anc_ok;
  logic [5:0][3:0]       tmr_owner;
  logic [5:0][11:0]      tmr_value;
  sse_pkg::sse_unit_t [5:0] tmr_unit;
  logic                  step_done_q, moved_q, busy_q;
  int                    n_errors = 0;
  int                    total_checks = 0;
  realtime               t0;
  // Late input changes mid-scan must not matter, as row 0 shows.
  sse_row_t rows [6] = '{
    '{32'h4, 32'h0, 4'h1, 1'b0, 4'h0},
    '{32'h7, 32'h7, 4'h3, 1'b1, 4'h1},
    '{32'h8, 32'h8, 4'h1, 1'b1, 4'h4},
    '{32'h0, 32'h0, 4'h4, 1'b1, 4'h2},
    '{32'h10, 32'h10, 4'h1, 1'b1, 4'h5},
    '{32'h1, 32'h1, 4'h2, 1'b1, 4'h0}};

  sse_engine dut_u (
    .clock(clock), .rst_b(rst_b), .loop_tick(loop_tick), .in_raw(in_raw),
    .init_state(init_state), .tr_valid(tr_valid), .tr_src(tr_src),
    .tr_dst(tr_dst), .tr_is_timer(tr_is_timer), .tr_sel(tr_sel),
    .tr_inv(tr_inv), .anc_id(anc_id), .anc_ok(anc_ok),
    .tmr_owner(tmr_owner), .tmr_value(tmr_value), .tmr_unit(tmr_unit),
    .cur_state_q(cur_state_q), .step_done_q(step_done_q),
    .moved_q(moved_q), .fired_q(fired_q), .busy_q(busy_q));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic step(input logic [31:0] v, input logic [31:0] late);
    int n;
    @(posedge clock);
    in_raw    <= v;
    loop_tick <= 1'b1;
    @(posedge clock);
    loop_tick <= 1'b0;
    in_raw    <= late;
    for (n = 0; n < 80; n++)
    begin
      @(posedge clock);
      #1;
      if (step_done_q === 1'b1)
        break;
    end
    if (n == 80)
    begin
      n_errors++;
      tally_and_finish();
    end
  endtask : step

  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    rst_b = 1'b0; loop_tick = 1'b0; in_raw = '0; init_state = 4'h1;
    tr_valid = 16'h003f; tr_is_timer = 16'h0008; tr_inv = 16'h0004;
    tr_src = '0; tr_dst = '0; tr_sel = '0; anc_id = '0; anc_ok = '0;
    tmr_owner = '0; tmr_value = '0;
    for (int s = 0; s < 16; s++)
    begin
      anc_id[s][0] = s[3:0];
      anc_ok[s][0] = 1'b1;
      if (s < 6)
        tmr_unit[s] = sse_pkg::UNIT_US;
    end
    anc_id[1][0] = 4'h8; anc_id[1][1] = 4'h1; anc_ok[1][1] = 1'b1;
    tr_src[0] = 4'h1; tr_dst[0] = 4'h2; tr_sel[0] = 5'h00;
    tr_src[1] = 4'h8; tr_dst[1] = 4'h3; tr_sel[1] = 5'h01;
    tr_src[2] = 4'h1; tr_dst[2] = 4'h4; tr_sel[2] = 5'h02;
    tr_src[3] = 4'h2; tr_dst[3] = 4'h1; tr_sel[3] = 5'h00;
    tr_src[4] = 4'h3; tr_dst[4] = 4'h1; tr_sel[4] = 5'h03;
    tr_src[5] = 4'h4; tr_dst[5] = 4'h1; tr_sel[5] = 5'h04;
    tmr_owner[0] = 4'h2; tmr_value[0] = 12'h00a;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    chk("start state", 32'h1, cur_state_q);
    foreach (rows[i])
    begin
      step(rows[i].v, rows[i].late);
      chk("state", rows[i].st, cur_state_q);
      chk("moved", rows[i].mv, moved_q);
      chk("fired", rows[i].fi, fired_q);
    end
    // Second lap proves the timer restarted on re-entry.
    for (int lap = 0; lap < 2; lap++)
    begin
      if (lap == 1)
        step(32'h1, 32'h1);
      chk("timer owner", 32'h2, cur_state_q);
      t0 = $realtime;
      for (int k = 0; k < 400 && cur_state_q === 4'h2; k++)
        step(32'h0, 32'h0);
      chk("timer lower", 32'h1, $realtime - t0 >= 40000.0);
      chk("timer upper", 32'h1, $realtime - t0 <= 70000.0);
      chk("timer fired", 32'h3, fired_q);
    end
    @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    #1;
    chk("reset state", 32'h0, cur_state_q);
    chk("reset busy", 32'h0, busy_q);
    @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    chk("reload state", 32'h1, cur_state_q);
    step(32'h1, 32'h1);
    chk("after reset", 32'h2, cur_state_q);
    tally_and_finish();
  end
endmodule : sse_engine_bench
